// ### logic/rcc_pkg.sv
// Function
// [RULE1] Config bit 15 enables the clock and calendar module when one and disables it when zero.
// [RULE2] Config bit 14 is not implemented, reads zero and ignores writes.
// [RULE3] The value window high and low halves accept writes only while the write unlock bit 13 is one.
// [RULE4] Bit 12 reads one while a counter rollover may ripple through the value window, else zero.
// [RULE5] While the ripple flag is set, software reads twice and keeps the value only if both agree.
// [RULE6] Bit 11 reads one during the second half of each second and zero during the first half.
// [RULE7] Bit 11 is read-only and clears when the seconds half of the minutes and seconds pair is written.
// [RULE8] Bit 10 drives the module output onto its pin when one and disables it when zero.
// [RULE9] The two-bit window pointer in bits 9-8 decrements on each access of the high half, stopping at zero.
// [RULE10] Pointer maps high byte to minutes, weekday, month, reserved and low byte to seconds, hours, day, year.
// [RULE11] Only power-on reset clears the configuration register; other resets leave it unchanged.
// [RULE12] A write to the enable bit takes effect only while the write unlock bit is one.
// [RULE13] Write unlock can be set only in the cycle right after the 55h then aah key sequence; the code accepts it on the next write, any cycles later.
// [RULE14] The high byte of the window reads zero while the pointer is three.
package rcc_pkg;
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_VAL    = 8'h04;
  localparam logic [7:0] ADDR_KEY    = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam int         BIT_EN      = 15;
  localparam int         BIT_UNLOCK  = 13;
  localparam int         BIT_RIPPLE  = 12;
  localparam int         BIT_HALF    = 11;
  localparam int         BIT_OE      = 10;
  localparam int         BIT_PTR     = 8;
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'haa;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         CLK_HZ      = 25000000;
  localparam int         HALF_SEC_MS = 500;
  localparam int         HALF_CYC    = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int         RIPPLE_CYC  = 32;
  localparam logic [7:0] MAX_SEC     = 8'h3b;
  localparam logic [7:0] MAX_MIN     = 8'h3b;
  localparam logic [7:0] MAX_HOUR    = 8'h17;
  localparam int         NUM_EVT     = 2;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_OPEN} rcc_key_e;
  typedef struct packed {
    logic       en;
    logic       unlock;
    logic       oe;
    logic [1:0] ptr;
  } rcc_cfg_s;
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rcc_time_s;
endpackage : rcc_pkg

// ### logic/rcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_top #(
  parameter int HALF_CYCLES = rcc_pkg::HALF_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        POR,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             CLK_OUT,
  output logic             CLK_OUT_OE,
  output logic             IRQ
);
  // Config clears only on POR; RESET clears bus, key, status and mask state only
  rcc_pkg::rcc_cfg_s   cfg_ff, nxt_cfg;
  rcc_pkg::rcc_time_s  tm_ff, nxt_tm;
  rcc_pkg::rcc_key_e   key_ff, nxt_key;
  logic [31:0]         cnt_ff, nxt_cnt;
  logic                half_ff, nxt_half;
  logic [5:0]          rip_ff, nxt_rip;
  logic [1:0]          st_ff, nxt_st, msk_ff, nxt_msk;
  logic                aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0]          awa_ff, nxt_awa;
  logic [31:0]         wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0]          ws_ff, nxt_ws;
  logic [1:0]          br_ff, nxt_br, rr_ff, nxt_rr;
  logic                do_wr, do_rd, tick, sec_roll;
  logic [7:0]          win_hi, win_lo;
  logic [1:0]          evt;

  assign do_wr    = aw_ff && w_ff && !bv_ff;
  assign do_rd    = ARVALID && !rv_ff;
  assign tick     = cfg_ff.en && (cnt_ff == HALF_CYCLES - 1); // RULE1
  assign sec_roll = tick && half_ff;

  always_comb begin
    win_hi = 8'h00;
    win_lo = 8'h00;
    case (cfg_ff.ptr) // RULE10
      2'h0: begin
        win_hi = tm_ff.min;
        win_lo = tm_ff.sec;
      end
      2'h1: begin
        win_hi = tm_ff.wday;
        win_lo = tm_ff.hour;
      end
      2'h2: begin
        win_hi = tm_ff.month;
        win_lo = tm_ff.day;
      end
      default: begin
        win_hi = 8'h00; // RULE14
        win_lo = tm_ff.year;
      end
    endcase
  end

  // Bus handshake and response registers
  always_comb begin
    nxt_aw  = aw_ff;
    nxt_awa = awa_ff;
    nxt_w   = w_ff;
    nxt_wd  = wd_ff;
    nxt_ws  = ws_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rd  = rd_ff;
    nxt_rr  = rr_ff;
    if (AWVALID && AWREADY) begin
      nxt_aw  = 1'b1;
      nxt_awa = AWADDR;
    end
    if (WVALID && WREADY) begin
      nxt_w  = 1'b1;
      nxt_wd = WDATA;
      nxt_ws = WSTRB;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = rcc_pkg::RESP_OKAY;
      if (awa_ff > rcc_pkg::ADDR_MASK || awa_ff[1:0] != 2'h0) begin
        nxt_br = rcc_pkg::RESP_SLVERR;
      end
    end else if (bv_ff && BREADY) begin
      nxt_bv = 1'b0;
    end
    if (do_rd) begin
      nxt_rv = 1'b1;
      nxt_rr = rcc_pkg::RESP_OKAY;
      nxt_rd = 32'h0000_0000; // RULE2
      if (ARADDR == rcc_pkg::ADDR_CFG) begin
        nxt_rd[rcc_pkg::BIT_EN]               = cfg_ff.en;
        nxt_rd[rcc_pkg::BIT_UNLOCK]           = cfg_ff.unlock;
        nxt_rd[rcc_pkg::BIT_RIPPLE]           = rip_ff != 6'h00; // RULE4
        nxt_rd[rcc_pkg::BIT_HALF]             = half_ff; // RULE6
        nxt_rd[rcc_pkg::BIT_OE]               = cfg_ff.oe;
        nxt_rd[rcc_pkg::BIT_PTR+1:rcc_pkg::BIT_PTR] = cfg_ff.ptr;
      end else if (ARADDR == rcc_pkg::ADDR_VAL) begin
        nxt_rd[15:0] = {win_hi, win_lo};
      end else if (ARADDR == rcc_pkg::ADDR_KEY) begin
        nxt_rd = 32'h0000_0000;
      end else if (ARADDR == rcc_pkg::ADDR_STAT) begin
        nxt_rd[1:0] = st_ff;
      end else if (ARADDR == rcc_pkg::ADDR_MASK) begin
        nxt_rd[1:0] = msk_ff;
      end else begin
        nxt_rr = rcc_pkg::RESP_SLVERR;
      end
    end else if (rv_ff && RREADY) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_ff  <= 1'b0;
      awa_ff <= 8'h00;
      w_ff   <= 1'b0;
      wd_ff  <= 32'h0000_0000;
      ws_ff  <= 4'h0;
      bv_ff  <= 1'b0;
      br_ff  <= 2'h0;
      rv_ff  <= 1'b0;
      rd_ff  <= 32'h0000_0000;
      rr_ff  <= 2'h0;
    end else begin
      aw_ff  <= nxt_aw;
      awa_ff <= nxt_awa;
      w_ff   <= nxt_w;
      wd_ff  <= nxt_wd;
      ws_ff  <= nxt_ws;
      bv_ff  <= nxt_bv;
      br_ff  <= nxt_br;
      rv_ff  <= nxt_rv;
      rd_ff  <= nxt_rd;
      rr_ff  <= nxt_rr;
    end
  end

  // Config, key sequence, timekeeping and events
  always_comb begin
    logic wcfg, wval, rval;
    wcfg     = do_wr && awa_ff == rcc_pkg::ADDR_CFG && ws_ff[1];
    wval     = do_wr && awa_ff == rcc_pkg::ADDR_VAL;
    rval     = do_rd && ARADDR == rcc_pkg::ADDR_VAL;
    nxt_cfg  = cfg_ff;
    nxt_key  = key_ff;
    nxt_tm   = tm_ff;
    nxt_cnt  = cnt_ff;
    nxt_half = half_ff;
    nxt_rip  = rip_ff;
    nxt_st   = st_ff;
    nxt_msk  = msk_ff;
    evt      = 2'h0;
    // Key register only arms on exact back-to-back writes
    if (do_wr && awa_ff == rcc_pkg::ADDR_KEY && ws_ff[0]) begin
      if (wd_ff[7:0] == rcc_pkg::KEY_FIRST) begin
        nxt_key = rcc_pkg::KEY_GOT1;
      end else if (wd_ff[7:0] == rcc_pkg::KEY_SECOND && key_ff == rcc_pkg::KEY_GOT1) begin
        nxt_key = rcc_pkg::KEY_OPEN;
      end else begin
        nxt_key = rcc_pkg::KEY_IDLE;
      end
    end else if (do_wr) begin
      nxt_key = rcc_pkg::KEY_IDLE; // RULE13
    end
    if (wcfg) begin
      if (cfg_ff.unlock) begin
        nxt_cfg.en = wd_ff[rcc_pkg::BIT_EN]; // RULE12
      end
      if (!wd_ff[rcc_pkg::BIT_UNLOCK] || key_ff == rcc_pkg::KEY_OPEN) begin
        nxt_cfg.unlock = wd_ff[rcc_pkg::BIT_UNLOCK]; // RULE13
      end
      nxt_cfg.oe  = wd_ff[rcc_pkg::BIT_OE]; // RULE8
      nxt_cfg.ptr = wd_ff[rcc_pkg::BIT_PTR+1:rcc_pkg::BIT_PTR];
    end
    if (tick) begin
      nxt_cnt  = 32'h0000_0000;
      nxt_half = !half_ff; // RULE6
    end else if (cfg_ff.en) begin
      nxt_cnt = cnt_ff + 32'h0000_0001;
    end
    // Ripple warning covers the cycles around each rollover
    if (cfg_ff.en && cnt_ff >= HALF_CYCLES - rcc_pkg::RIPPLE_CYC && half_ff) begin
      nxt_rip = 6'(rcc_pkg::RIPPLE_CYC); // RULE4
    end else if (rip_ff != 6'h00) begin
      nxt_rip = rip_ff - 6'h01;
    end
    if (sec_roll) begin
      evt[0]     = 1'b1;
      nxt_tm.sec = tm_ff.sec + 8'h01;
      if (tm_ff.sec == rcc_pkg::MAX_SEC) begin
        nxt_tm.sec = 8'h00;
        nxt_tm.min = tm_ff.min + 8'h01;
        if (tm_ff.min == rcc_pkg::MAX_MIN) begin
          nxt_tm.min  = 8'h00;
          nxt_tm.hour = tm_ff.hour + 8'h01;
          if (tm_ff.hour == rcc_pkg::MAX_HOUR) begin
            nxt_tm.hour = 8'h00;
            evt[1]      = 1'b1;
          end
        end
      end
    end
    if (wval && cfg_ff.unlock) begin // RULE3
      case (cfg_ff.ptr)
        2'h0: begin
          if (ws_ff[1]) nxt_tm.min = wd_ff[15:8];
          if (ws_ff[0]) begin
            nxt_tm.sec = wd_ff[7:0];
            nxt_half   = 1'b0; // RULE7
            nxt_cnt    = 32'h0000_0000;
          end
        end
        2'h1: begin
          if (ws_ff[1]) nxt_tm.wday = wd_ff[15:8];
          if (ws_ff[0]) nxt_tm.hour = wd_ff[7:0];
        end
        2'h2: begin
          if (ws_ff[1]) nxt_tm.month = wd_ff[15:8];
          if (ws_ff[0]) nxt_tm.day = wd_ff[7:0];
        end
        default: begin
          if (ws_ff[0]) nxt_tm.year = wd_ff[7:0];
        end
      endcase
    end
    if ((rval || (wval && ws_ff[1])) && cfg_ff.ptr != 2'h0 && !wcfg) begin
      nxt_cfg.ptr = cfg_ff.ptr - 2'h1; // RULE9
    end
    if (do_wr && awa_ff == rcc_pkg::ADDR_MASK) begin
      nxt_msk = wd_ff[1:0];
    end
    if (do_wr && awa_ff == rcc_pkg::ADDR_STAT) begin
      nxt_st = st_ff & ~wd_ff[1:0];
    end
    nxt_st = nxt_st | evt;
  end

  always_ff @(posedge SYS_CLK) begin
    if (POR) begin // RULE11
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (POR) begin
      tm_ff   <= '0;
      cnt_ff  <= 32'h0000_0000;
      half_ff <= 1'b0;
      rip_ff  <= 6'h00;
    end else begin
      tm_ff   <= nxt_tm;
      cnt_ff  <= nxt_cnt;
      half_ff <= nxt_half;
      rip_ff  <= nxt_rip;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET || POR) begin
      key_ff <= rcc_pkg::KEY_IDLE;
      st_ff  <= 2'h0;
      msk_ff <= 2'h0;
    end else begin
      key_ff <= nxt_key;
      st_ff  <= nxt_st;
      msk_ff <= nxt_msk;
    end
  end

  assign AWREADY    = !aw_ff;
  assign WREADY     = !w_ff;
  assign BVALID     = bv_ff;
  assign BRESP      = br_ff;
  assign ARREADY    = !rv_ff;
  assign RVALID     = rv_ff;
  assign RDATA      = rd_ff;
  assign RRESP      = rr_ff;
  assign CLK_OUT    = half_ff;
  assign CLK_OUT_OE = cfg_ff.oe; // RULE8
  assign IRQ        = |(st_ff & msk_ff);
  logic wcfg_c;
  assign wcfg_c = do_wr && awa_ff == rcc_pkg::ADDR_CFG && ws_ff[1];

  a_ptr_decr: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE9
    (do_rd && ARADDR == rcc_pkg::ADDR_VAL && cfg_ff.ptr != 2'h0 && !do_wr)
      |=> cfg_ff.ptr == $past(cfg_ff.ptr) - 2'h1)
    else $error("pointer did not decrement");
  a_ptr_floor: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE9
    (cfg_ff.ptr == 2'h0 && !do_wr) |=> cfg_ff.ptr == 2'h0)
    else $error("pointer wrapped below zero");
  a_en_locked: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE12
    !cfg_ff.unlock |=> cfg_ff.en == $past(cfg_ff.en))
    else $error("enable changed while locked");
  a_val_locked: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE3
    (!cfg_ff.unlock && !sec_roll) |=> tm_ff == $past(tm_ff))
    else $error("time changed while locked");
  a_unlock_key: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE13
    $rose(cfg_ff.unlock) |-> $past(key_ff) == rcc_pkg::KEY_OPEN)
    else $error("unlock set without key");
  a_half_clear: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE7
    (do_wr && awa_ff == rcc_pkg::ADDR_VAL && cfg_ff.unlock && cfg_ff.ptr == 2'h0 && ws_ff[0])
      |=> !half_ff)
    else $error("half flag not cleared");
  a_half_stop: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE1
    (!cfg_ff.en && !do_wr) |=> $stable(half_ff) && $stable(tm_ff))
    else $error("clock ran while disabled");
  a_hi_resv: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE14
    (do_rd && ARADDR == rcc_pkg::ADDR_VAL && cfg_ff.ptr == 2'h3) |=> RDATA[15:8] == 8'h00)
    else $error("reserved byte not zero");
  a_oe_pin: assert property (@(posedge SYS_CLK) disable iff (RESET || POR) // RULE8
    wcfg_c |=> CLK_OUT_OE == $past(wd_ff[rcc_pkg::BIT_OE]))
    else $error("pin enable not written");
  c_unlock: cover property (@(posedge SYS_CLK) $rose(cfg_ff.unlock));
  c_ptr_walk: cover property (@(posedge SYS_CLK) cfg_ff.ptr == 2'h3 ##[1:20] cfg_ff.ptr == 2'h0);
  c_irq: cover property (@(posedge SYS_CLK) $rose(IRQ));
endmodule : rcc_top
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic             SYS_CLK, RESET, POR, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [7:0]       AWADDR, ARADDR;
  logic [31:0]      WDATA;
  logic [3:0]       WSTRB;
  wire logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CLK_OUT, CLK_OUT_OE, IRQ;
  wire logic [1:0]  BRESP, RRESP;
  wire logic [31:0] RDATA;
  int               errors, tests_run;
  logic [31:0]      rd_q;
  logic [1:0]       rsp_q;
  // Ripple and half-second bits move on their own, so they are left out of plain compares
  localparam logic [31:0] CFG_MASK = 32'h0000e700;

  rcc_top #(.HALF_CYCLES(40)) dut (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .POR(POR),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CLK_OUT(CLK_OUT), .CLK_OUT_OE(CLK_OUT_OE), .IRQ(IRQ)
  );

  always #20 SYS_CLK = ~SYS_CLK;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Ready lines stay high throughout, so back-to-back calls never reassign them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 100);
    rsp_q = BRESP;
    chk("write answered", 1'b1, n < 100);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 100);
    rd_q = RDATA;
    rsp_q = RRESP;
    chk("read answered", 1'b1, n < 100);
  endtask : rd

  task automatic open_cfg(input logic [31:0] cfg);
    wr(rcc_pkg::ADDR_KEY, {24'h0, rcc_pkg::KEY_FIRST});
    wr(rcc_pkg::ADDR_KEY, {24'h0, rcc_pkg::KEY_SECOND});
    wr(rcc_pkg::ADDR_CFG, cfg);
  endtask : open_cfg

  task automatic t_reset_vals;
    rd(rcc_pkg::ADDR_CFG);
    chk("config after power-on", 32'h0, rd_q & CFG_MASK);
    chk("pin enable after power-on", 1'b0, CLK_OUT_OE);
    chk("irq after power-on", 1'b0, IRQ);
  endtask : t_reset_vals

  task automatic t_locked_cfg;
    wr(rcc_pkg::ADDR_CFG, 32'h0000c700);
    rd(rcc_pkg::ADDR_CFG);
    chk("config without unlock", 32'h00000700, rd_q & CFG_MASK);
    chk("pin enable set", 1'b1, CLK_OUT_OE);
  endtask : t_locked_cfg

  task automatic t_window;
    logic [15:0] wv [4];
    logic [15:0] ev [5];
    wv = '{16'hff24, 16'h0715, 16'h0305, 16'h3412};
    ev = '{16'h0024, 16'h0715, 16'h0305, 16'h3412, 16'h3412};
    open_cfg(32'h00002300);
    rd(rcc_pkg::ADDR_CFG);
    chk("config after unlock", 32'h00002300, rd_q & CFG_MASK);
    chk("pin enable cleared", 1'b0, CLK_OUT_OE);
    for (int i = 0; i < 4; i++) wr(rcc_pkg::ADDR_VAL, {16'h0, wv[i]});
    rd(rcc_pkg::ADDR_CFG);
    chk("pointer after writes", 32'h00002000, rd_q & CFG_MASK);
    open_cfg(32'h00002300);
    for (int i = 0; i < 5; i++) begin
      rd(rcc_pkg::ADDR_VAL);
      chk("window read", {16'h0, ev[i]}, rd_q);
    end
  endtask : t_window

  task automatic t_lock;
    wr(rcc_pkg::ADDR_CFG, 32'h00000300);
    wr(rcc_pkg::ADDR_KEY, {24'h0, rcc_pkg::KEY_FIRST});
    wr(rcc_pkg::ADDR_KEY, {24'h0, rcc_pkg::KEY_SECOND});
    wr(rcc_pkg::ADDR_MASK, 32'h0);
    wr(rcc_pkg::ADDR_CFG, 32'h00002300);
    rd(rcc_pkg::ADDR_CFG);
    chk("late unlock refused", 32'h00000300, rd_q & CFG_MASK);
    wr(rcc_pkg::ADDR_VAL, 32'h0000ffff);
    wr(rcc_pkg::ADDR_CFG, 32'h00000300);
    rd(rcc_pkg::ADDR_VAL);
    chk("locked window", 32'h00000024, rd_q);
  endtask : t_lock

  task automatic t_soft_reset;
    RESET <= 1'b1;
    @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    rd(rcc_pkg::ADDR_CFG);
    chk("config over reset", 32'h00000200, rd_q & CFG_MASK);
  endtask : t_soft_reset

  task automatic t_run;
    logic [1:0]  seen_half, seen_rip;
    int          n;
    logic [31:0] v;
    seen_half = 2'b00;
    seen_rip = 2'b00;
    open_cfg(32'h00002000);
    wr(rcc_pkg::ADDR_CFG, 32'h0000a000);
    rd(rcc_pkg::ADDR_CFG);
    chk("enable with unlock", 32'h0000a000, rd_q & CFG_MASK);
    for (int i = 0; i < 60; i++) begin
      rd(rcc_pkg::ADDR_CFG);
      seen_half[rd_q[rcc_pkg::BIT_HALF]] = 1'b1;
      seen_rip[rd_q[rcc_pkg::BIT_RIPPLE]] = 1'b1;
    end
    chk("half flag both phases", 2'b11, seen_half);
    chk("ripple flag both states", 2'b11, seen_rip);
    n = 0;
    do begin
      rd(rcc_pkg::ADDR_CFG);
      n++;
    end while ((rd_q[rcc_pkg::BIT_HALF] !== 1'b1 || rd_q[rcc_pkg::BIT_RIPPLE] !== 1'b0) && n < 60);
    chk("quiet second half found", 1'b1, n < 60);
    chk("clock pin in second half", 1'b1, CLK_OUT);
    // No rollover can land within the next few reads, so both must agree
    rd(rcc_pkg::ADDR_VAL);
    v = rd_q;
    rd(rcc_pkg::ADDR_VAL);
    chk("repeated window read", v, rd_q);
    wr(rcc_pkg::ADDR_VAL, 32'h00000000, 4'h1);
    rd(rcc_pkg::ADDR_CFG);
    chk("half flag after seconds write", 1'b0, rd_q[rcc_pkg::BIT_HALF]);
    chk("clock pin after seconds write", 1'b0, CLK_OUT);
  endtask : t_run

  task automatic t_irq;
    int n;
    n = 0;
    wr(rcc_pkg::ADDR_MASK, 32'h0);
    wr(rcc_pkg::ADDR_STAT, 32'h3);
    do begin
      rd(rcc_pkg::ADDR_STAT);
      n++;
    end while (rd_q[0] !== 1'b1 && n < 60);
    chk("tick status", 1'b1, rd_q[0]);
    chk("masked irq", 1'b0, IRQ);
    wr(rcc_pkg::ADDR_MASK, 32'h1);
    chk("unmasked irq", 1'b1, IRQ);
    wr(rcc_pkg::ADDR_STAT, 32'h3);
    chk("irq after clear", 1'b0, IRQ);
    // Preset one second before midnight and wait for the day event
    wr(rcc_pkg::ADDR_CFG, 32'h0000a100);
    wr(rcc_pkg::ADDR_VAL, 32'h00000017);
    wr(rcc_pkg::ADDR_VAL, 32'h00003b3b);
    n = 0;
    do begin
      rd(rcc_pkg::ADDR_STAT);
      n++;
    end while (rd_q[1] !== 1'b1 && n < 60);
    chk("day status", 1'b1, rd_q[1]);
    rd(rcc_pkg::ADDR_VAL);
    chk("window after midnight", 32'h0, rd_q);
    wr(rcc_pkg::ADDR_STAT, 32'h3);
  endtask : t_irq

  task automatic t_unmapped;
    rd(8'h40);
    chk("unmapped read resp", rcc_pkg::RESP_SLVERR, rsp_q);
    chk("unmapped read data", 32'h0, rd_q);
    wr(8'h40, 32'h1);
    chk("unmapped write resp", rcc_pkg::RESP_SLVERR, rsp_q);
  endtask : t_unmapped

  task automatic print_verdict;
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (30000) @(posedge SYS_CLK);
    errors++;
    $display("unexpected watchdog: expected done, seen hang");
    print_verdict();
  end

  initial begin
    SYS_CLK = 1'b0;
    RESET = 1'b1;
    POR = 1'b1;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    ARVALID = 1'b0;
    BREADY = 1'b1;
    RREADY = 1'b1;
    AWADDR = 8'h0;
    ARADDR = 8'h0;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge SYS_CLK);
    POR <= 1'b0;
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    t_reset_vals();
    t_locked_cfg();
    t_window();
    t_lock();
    t_soft_reset();
    t_run();
    t_irq();
    t_unmapped();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
